/* uxp_port.sv */
// dual-role byte-wide cell port, either layer role by strap
// assumes link clocks well below clk_i/4; partner keeps soc timing
`timescale 1ns/100ps
`default_nettype none

module uxp_port
  import uxp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       role_select_strap_i,
  input  wire logic       multi_port_variant_i,
  input  wire logic       out_link_clk_i,
  input  wire logic       in_link_clk_i,
  output logic      [7:0] out_bytes_o,
  output logic            out_cell_start_o,
  output logic            out_bytes_oe_o,
  output logic            out_flag_o,
  output logic            out_flag_oe_o,
  input  wire logic       out_flow_i,
  input  wire logic [7:0] in_bytes_i,
  input  wire logic       in_cell_start_i,
  input  wire logic       in_status_i,
  output logic            in_ctrl_o,
  output logic            in_ctrl_oe_o,
  input  wire logic       phy_role_rx_select_n_i,
  input  wire logic       phy_role_tx_select_n_i,
  input  wire logic [7:0] src_byte_i,
  input  wire logic       src_cell_ready_i,
  output logic            src_take_o,
  output logic      [7:0] snk_byte_o,
  output logic            snk_start_o,
  output logic            snk_valid_o,
  input  wire logic       snk_room_i
);

  logic [SYNC_W-1:0] sv;
  logic              role_ff;
  logic              multi_ff;
  logic              oclk_ff;
  logic              iclk_ff;
  logic              atm;
  logic              multi_port_variant;
  logic              out_rise;
  logic              out_fall;
  logic              in_rise;
  logic              in_fall;

  // all pins through one synchroniser
  uxp_pin_sync u_sync (
    .clk_i (clk_i),
    .pin_i ({in_bytes_i, multi_port_variant_i, phy_role_tx_select_n_i,
             phy_role_rx_select_n_i, in_cell_start_i, in_status_i,
             out_flow_i, role_select_strap_i, in_link_clk_i,
             out_link_clk_i}),
    .val_o (sv)
  );

  // tracks through reset, so no false edge right after release
  always_ff @(posedge clk_i)
  begin
    oclk_ff <= sv[SB_OCLK];
    iclk_ff <= sv[SB_ICLK];
  end

  // link clock edges seen in the clk_i domain
  assign out_rise = sv[SB_OCLK] && !oclk_ff;
  assign out_fall = !sv[SB_OCLK] && oclk_ff;
  assign in_rise  = sv[SB_ICLK] && !iclk_ff;
  assign in_fall  = !sv[SB_ICLK] && iclk_ff;

  assign atm  = (role_ff == ROLE_ATM);
  assign multi_port_variant = !atm && multi_ff;

  // outgoing direction
  logic       flow_snap_ff;
  logic       rsel_snap_ff;
  logic       flow_edge_ff;
  logic       rsel_ff;
  logic [5:0] oidx;
  logic       obusy;
  logic       rd_fell;
  logic       rsel_cur;
  logic       granted;
  logic       send_ok;
  logic       out_move;
  logic       clav;

  // mid-cycle snapshot, used at the next rising edge
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flow_snap_ff <= 1'b1;
      rsel_snap_ff <= 1'b1;
      flow_edge_ff <= 1'b1;
    end
    else
    begin
      if (out_fall)
      begin
        flow_snap_ff <= sv[SB_FLOW];
        rsel_snap_ff <= sv[SB_RSEL];
      end
      if (out_rise)
        flow_edge_ff <= flow_snap_ff;
    end
  end

  assign rd_fell  = flow_edge_ff && !flow_snap_ff;
  assign rsel_cur = rd_fell ? !rsel_snap_ff : rsel_ff;
  assign granted  = !flow_snap_ff && (!multi_port_variant || rsel_cur);
  // stop at once on full, well inside the slack
  assign send_ok  = atm && flow_snap_ff
                    && (obusy || src_cell_ready_i);
  assign out_move = atm ? send_ok
                        : (granted && (obusy || src_cell_ready_i));
  assign clav     = src_cell_ready_i || obusy;

  uxp_cell_count u_ocnt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .step_i    (out_rise && out_move),
    .start_i   (oidx == CELL_FIRST),
    .idx_o     (oidx),
    .busy_o    (obusy)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      out_bytes_o      <= BYTES_RST;
      out_cell_start_o <= SOC_RST;
      out_flag_o       <= FLAG_RST;
      src_take_o       <= 1'b0;
      rsel_ff          <= 1'b0;
    end
    else
    begin
      src_take_o <= out_rise && out_move;
      if (out_rise)
      begin
        rsel_ff          <= rsel_cur;
        out_flag_o       <= atm ? !send_ok : clav;
        out_cell_start_o <= out_move && (oidx == CELL_FIRST);
        if (out_move)
          out_bytes_o <= src_byte_i;
      end
    end
  end

  // incoming direction
  logic [7:0] idata_snap_ff;
  logic       isoc_snap_ff;
  logic       stat_snap_ff;
  logic       tsel_snap_ff;
  logic       stat_edge_ff;
  logic       tsel_ff;
  logic       ren_d1_ff;
  logic [5:0] iidx;
  logic       ibusy;
  logic       wr_fell;
  logic       tsel_cur;
  logic       in_valid;
  logic       in_step;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      idata_snap_ff <= BYTES_RST;
      isoc_snap_ff  <= SOC_RST;
      stat_snap_ff  <= 1'b1;
      tsel_snap_ff  <= 1'b1;
      stat_edge_ff  <= 1'b1;
      tsel_ff       <= 1'b0;
      ren_d1_ff     <= 1'b1;
    end
    else
    begin
      if (in_fall)
      begin
        idata_snap_ff <= sv[SB_DATA +: 8];
        isoc_snap_ff  <= sv[SB_SOC];
        stat_snap_ff  <= sv[SB_STAT];
        tsel_snap_ff  <= sv[SB_TSEL];
      end
      if (in_rise)
      begin
        stat_edge_ff <= stat_snap_ff;
        tsel_ff      <= tsel_cur;
        ren_d1_ff    <= in_ctrl_o;
      end
    end
  end

  assign wr_fell  = stat_edge_ff && !stat_snap_ff;
  assign tsel_cur = wr_fell ? !tsel_snap_ff : tsel_ff;
  // atm: byte due one cycle after read enable, unless empty
  assign in_valid = atm ? (!ren_d1_ff && stat_snap_ff)
                        : (!stat_snap_ff && (!multi_port_variant || tsel_cur));
  // bytes before a start flag are dropped
  assign in_step  = in_rise && in_valid
                    && (isoc_snap_ff || ibusy);

  uxp_cell_count u_icnt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .step_i    (in_step),
    .start_i   (isoc_snap_ff),
    .idx_o     (iidx),
    .busy_o    (ibusy)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_ctrl_o   <= CTRL_RST;
      snk_valid_o <= 1'b0;
      snk_start_o <= 1'b0;
      snk_byte_o  <= BYTES_RST;
    end
    else
    begin
      snk_valid_o <= in_step;
      if (in_step)
      begin
        snk_byte_o  <= idata_snap_ff;
        snk_start_o <= isoc_snap_ff;
      end
      if (in_rise)
        in_ctrl_o <= atm ? !(snk_room_i || ibusy)
                         : snk_room_i;
    end
  end

  // role and output enables follow strap even during reset
  always_ff @(posedge clk_i)
  begin
    role_ff  <= sv[SB_STRAP];
    multi_ff <= sv[SB_MULTI];
    if (sys_rst_i)
    begin
      out_bytes_oe_o <= atm;
      out_flag_oe_o  <= atm;
      in_ctrl_oe_o   <= atm;
    end
    else
    begin
      if (out_rise)
      begin
        out_bytes_oe_o <= atm || granted;
        out_flag_oe_o  <= atm || !multi_port_variant || !rsel_snap_ff;
      end
      if (in_rise)
        in_ctrl_oe_o <= atm || !multi_port_variant || !tsel_snap_ff;
    end
  end

  // checks
  logic [2:0] wr_after_full_ff;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wr_after_full_ff <= 3'h0;
    else if (out_rise)
    begin
      if (flow_snap_ff || !atm)
        wr_after_full_ff <= 3'h0;
      else if (out_move && (wr_after_full_ff != WR_MAX))
        wr_after_full_ff <= wr_after_full_ff + WR_STEP;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking

  sequence strap_held_s;
    $stable(sv[SB_STRAP]) [*2];
  endsequence

  sequence held_reset_s;
    sys_rst_i && $past(sys_rst_i) && $stable(role_ff);
  endsequence

  role_strap_a:
    assert property (disable iff (sys_rst_i)
      strap_held_s |-> (role_ff == $past(sv[SB_STRAP])))
    else $error("role does not follow strap");

  out_sync_a:
    assert property (disable iff (sys_rst_i)
      (!$stable(out_bytes_o) || !$stable(out_flag_o)) |-> $past(out_rise))
    else $error("outgoing pin changed off the link edge");

  in_sync_a:
    assert property (disable iff (sys_rst_i)
      snk_valid_o |-> $past(in_rise))
    else $error("byte taken off the link edge");

  single_port_variant_drive_a:
    assert property (disable iff (sys_rst_i)
      (!atm && !multi_port_variant && out_bytes_oe_o) |-> !flow_edge_ff)
    else $error("bus driven without prior read enable");

  multi_port_variant_drive_a:
    assert property (disable iff (sys_rst_i)
      (!atm && multi_port_variant && out_bytes_oe_o) |-> (rsel_ff && !flow_edge_ff))
    else $error("bus driven while not selected");

  wen_start_a:
    assert property (disable iff (sys_rst_i)
      (atm && $fell(out_flag_o)) |-> $past(src_cell_ready_i || obusy)
                                      && src_take_o)
    else $error("write enable without a cell");

  clav_cell_a:
    assert property (disable iff (sys_rst_i)
      (!atm && $rose(out_flag_o)) |-> $past(src_cell_ready_i || obusy))
    else $error("cell available without a cell");

  clav_float_a:
    assert property (disable iff (sys_rst_i)
      (multi_port_variant && $rose(out_flag_oe_o)) |-> $past(!rsel_snap_ff && out_rise))
    else $error("cell flag driven without select");

  full_slack_a:
    assert property (disable iff (sys_rst_i)
      wr_after_full_ff <= FULL_SLACK)
    else $error("too many writes after full");

  rst_atm_a:
    assert property (
      (held_reset_s and atm) |-> out_bytes_oe_o && out_flag_oe_o
        && (out_bytes_o == BYTES_RST) && (out_flag_o == FLAG_RST))
    else $error("atm role reset levels wrong");

  rst_phy_a:
    assert property ((held_reset_s and !atm) |-> !out_bytes_oe_o
                                              && !out_flag_oe_o)
    else $error("phy role pins not floating in reset");

  ren_room_a:
    assert property (disable iff (sys_rst_i)
      (atm && $fell(in_ctrl_o)) |-> $past(snk_room_i || ibusy))
    else $error("read enable without room");

  tx_sel_a:
    assert property (disable iff (sys_rst_i)
      (multi_port_variant && snk_valid_o) |-> tsel_ff)
    else $error("byte accepted while not selected");

  cell_len_a:
    assert property (disable iff (sys_rst_i)
      (snk_valid_o && !snk_start_o) |-> $past(ibusy, 2))
    else $error("cell length broken");

  idx_range_a:
    assert property (disable iff (sys_rst_i)
      (iidx <= CELL_LAST) && (oidx <= CELL_LAST))
    else $error("cell index out of range");

endmodule

`default_nettype wire

/* uxp_pkg.sv */
// constants shared by the dual-role cell port
// assumes one system clock of 40 MHz samples both link clocks
package uxp_pkg;

  localparam logic ROLE_ATM = 1'b0;
  localparam logic ROLE_PHY = 1'b1;

  // cell of 53 bytes, index of next byte 0..52
  localparam logic [5:0] CELL_FIRST  = 6'h00;
  localparam logic [5:0] CELL_SECOND = 6'h01;
  localparam logic [5:0] CELL_LAST   = 6'h34;
  localparam logic [5:0] CELL_STEP   = 6'h01;

  // writes allowed after full is seen
  localparam logic [2:0] FULL_SLACK = 3'h4;
  localparam logic [2:0] WR_STEP    = 3'h1;
  localparam logic [2:0] WR_MAX     = 3'h7;

  // reset values of pin drivers
  localparam logic [7:0] BYTES_RST = 8'h00;
  localparam logic       SOC_RST   = 1'b0;
  localparam logic       FLAG_RST  = 1'b1;
  localparam logic       CTRL_RST  = 1'b0;

  // bit positions in the pin synchroniser
  localparam int unsigned SYNC_W   = 17;
  localparam int unsigned SB_OCLK  = 0;
  localparam int unsigned SB_ICLK  = 1;
  localparam int unsigned SB_STRAP = 2;
  localparam int unsigned SB_FLOW  = 3;
  localparam int unsigned SB_STAT  = 4;
  localparam int unsigned SB_SOC   = 5;
  localparam int unsigned SB_RSEL  = 6;
  localparam int unsigned SB_TSEL  = 7;
  localparam int unsigned SB_MULTI = 8;
  localparam int unsigned SB_DATA  = 9;

endpackage

/* uxp_pin_sync.sv */
// three-stage synchroniser for all link pins
// assumes pins are asynchronous to clk_i; no reset, pins are data
`timescale 1ns/100ps
`default_nettype none

module uxp_pin_sync
  import uxp_pkg::*;
(
  input  wire logic [SYNC_W-1:0] pin_i,
  input  wire logic              clk_i,
  output logic      [SYNC_W-1:0] val_o
);

  logic [SYNC_W-1:0] s1_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] val_ff;
  logic [SYNC_W-1:0] nxt_val;

  always_ff @(posedge clk_i)
  begin
    s1_ff  <= pin_i;
    s2_ff  <= s1_ff;
    s3_ff  <= s2_ff;
    val_ff <= nxt_val;
  end

  // a change counts once stages two and three agree
  for (genvar g = 0; g < SYNC_W; g++)
  begin : g_bit
    assign nxt_val[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : val_ff[g];
  end

  assign val_o = val_ff;

endmodule

`default_nettype wire

/* uxp_cell_count.sv */
// byte position counter within a 53-byte cell
// assumes step_i is a one-cycle pulse per byte moved
`timescale 1ns/100ps
`default_nettype none

module uxp_cell_count
  import uxp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       step_i,
  input  wire logic       start_i,
  output logic      [5:0] idx_o,
  output logic            busy_o
);

  logic [5:0] idx_ff;
  logic [5:0] nxt_idx;

  always_comb
  begin
    nxt_idx = idx_ff;
    if (step_i)
    begin
      if (start_i)
        nxt_idx = CELL_SECOND;
      else if (idx_ff == CELL_LAST)
        nxt_idx = CELL_FIRST;
      else
        nxt_idx = idx_ff + CELL_STEP;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      idx_ff <= CELL_FIRST;
    else
      idx_ff <= nxt_idx;
  end

  assign idx_o  = idx_ff;
  assign busy_o = (idx_ff != CELL_FIRST);

endmodule

`default_nettype wire

/* uxp_link_model.sv */
// far-side partner of the cell port in atm role: a phy framing device
// assumes tb sets base_i before raising send_i; link clocks run free
`timescale 1ns/100ps
`default_nettype none

module uxp_link_model
(
  input  wire logic       rd_n_i,
  input  wire logic       full_req_i,
  input  wire logic       send_i,
  input  wire logic [7:0] base_i,
  output logic            out_clk_o,
  output logic            in_clk_o,
  output logic            full_n_o,
  output logic      [7:0] bytes_o,
  output logic            soc_o,
  output logic            empty_n_o
);
  int   left;
  int   idx;
  logic armed;

  initial
  begin
    out_clk_o = 1'b0;
    in_clk_o  = 1'b0;
    full_n_o  = 1'b1;
    bytes_o   = 8'h00;
    soc_o     = 1'b0;
    empty_n_o = 1'b0;
    left      = 0;
    idx       = 0;
    armed     = 1'b0;
    #37;
    forever #100 in_clk_o = ~in_clk_o;
  end

  always #100 out_clk_o = ~out_clk_o;

  always @(posedge out_clk_o)
    full_n_o <= ~full_req_i;

  // byte goes out in the cycle after read enable is seen low
  always @(posedge in_clk_o)
  begin
    if (send_i && !armed)
    begin
      left = 53;
      idx  = 0;
    end
    armed = send_i;
    if (!rd_n_i && left > 0)
    begin
      bytes_o   <= base_i + idx[7:0];
      soc_o     <= (idx == 0);
      empty_n_o <= 1'b1;
      idx       = idx + 1;
      left      = left - 1;
    end
    else
    begin
      bytes_o   <= ~bytes_o;
      soc_o     <= 1'b0;
      empty_n_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* uxp_port_tb.sv */
// self-checking bench for the dual-role cell port
// assumes uxp_link_model as far side; atm role first, then phy role
`timescale 1ns/100ps
`default_nettype none

module uxp_port_tb;
  import uxp_pkg::*;

  logic       clk_i, sys_rst_i, strap, multi, src_rdy, take;
  logic [7:0] src_byte, ob, ib, sb, base;
  logic       osoc, ooe, oflag, ofoe, ctrl, ctoe, isoc, ist, full_n;
  logic       ssoc, sval, room, full_req, send, oclk, iclk;
  logic       rsel_n, tsel_n;
  logic [8:0] txq[$];
  logic [8:0] rxq[$];
  logic [8:0] e;
  int         seed, fails, total_checks, late_wr, k;

  uxp_port u_uxp_port (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .role_select_strap_i(strap), .multi_port_variant_i(multi),
    .out_link_clk_i(oclk), .in_link_clk_i(iclk),
    .out_bytes_o(ob), .out_cell_start_o(osoc), .out_bytes_oe_o(ooe),
    .out_flag_o(oflag), .out_flag_oe_o(ofoe), .out_flow_i(full_n),
    .in_bytes_i(ib), .in_cell_start_i(isoc), .in_status_i(ist),
    .in_ctrl_o(ctrl), .in_ctrl_oe_o(ctoe),
    .phy_role_rx_select_n_i(rsel_n), .phy_role_tx_select_n_i(tsel_n),
    .src_byte_i(src_byte), .src_cell_ready_i(src_rdy), .src_take_o(take),
    .snk_byte_o(sb), .snk_start_o(ssoc), .snk_valid_o(sval),
    .snk_room_i(room));

  uxp_link_model u_uxp_link_model (
    .rd_n_i(ctrl), .full_req_i(full_req), .send_i(send), .base_i(base),
    .out_clk_o(oclk), .in_clk_o(iclk), .full_n_o(full_n),
    .bytes_o(ib), .soc_o(isoc), .empty_n_o(ist));

  always #12.5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic send_cell();
    int j, t;
    src_rdy = 1'b1;
    for (j = 0; j < 53; j++)
    begin
      for (t = 0; t < 400 && take !== 1'b1; t++)
        @(negedge clk_i);
      if (t >= 400)
      begin
        fails++;
        final_report();
      end
      txq.push_back({j == 0, src_byte});
      src_byte = $random(seed);
      if (j == 52)
        src_rdy = 1'b0;
      @(negedge clk_i);
    end
  endtask

  task automatic drain(input int n);
    int i;
    for (i = 0; i < n && txq.size() + rxq.size() > 0; i++)
      @(negedge clk_i);
    if (i >= n)
    begin
      fails++;
      final_report();
    end
  endtask

  // written bytes seen by the partner at its link clock rise
  always @(posedge oclk)
    if (strap === ROLE_ATM && oflag === 1'b0 && ooe === 1'b1)
    begin
      if (full_n === 1'b0)
        late_wr++;
      if (txq.size() == 0)
        check("tx extra", 12'h1, 12'h0);
      else
      begin
        e = txq.pop_front();
        check("tx byte", {3'h0, osoc, ob}, {3'h0, e});
      end
    end

  always @(posedge clk_i)
    if (sval === 1'b1)
    begin
      if (rxq.size() == 0)
        check("rx extra", 12'h1, 12'h0);
      else
      begin
        e = rxq.pop_front();
        check("rx byte", {3'h0, ssoc, sb}, {3'h0, e});
      end
    end

  initial
  begin
    clk_i = 1'b0; sys_rst_i = 1'b1; strap = 1'b0; multi = 1'b0;
    src_rdy = 1'b0; room = 1'b0; full_req = 1'b0; send = 1'b0;
    rsel_n = 1'b1; tsel_n = 1'b1;
    seed = 39378; fails = 0; total_checks = 0; late_wr = 0;
    src_byte = $random(seed);
    base = $random(seed);
    repeat (8) @(negedge clk_i);
    check("atm reset", {ooe, ofoe, oflag, osoc, ob}, 12'he00);
    sys_rst_i = 1'b0;
    repeat (40) @(negedge clk_i);
    check("atm idle", {10'h0, oflag, ctrl}, 12'h3);
    $display("test atm idle done");
    for (k = 0; k < 53; k++)
      rxq.push_back({k == 0, base + k[7:0]});
    room = 1'b1;
    send = 1'b1;
    fork
      send_cell();
      begin
        repeat (100) @(negedge clk_i);
        full_req = 1'b1;
        repeat (120) @(negedge clk_i);
        full_req = 1'b0;
      end
    join
    drain(3000);
    check("late writes", {11'h0, late_wr <= 4}, 12'h1);
    $display("test atm cells done");
    sys_rst_i = 1'b1;
    strap = ROLE_PHY;
    repeat (8) @(negedge clk_i);
    check("phy reset", {9'h0, ooe, ofoe, ctoe}, 12'h0);
    sys_rst_i = 1'b0;
    src_rdy = 1'b1;
    repeat (40) @(negedge clk_i);
    check("phy flags", {9'h0, oflag, ooe, ctrl}, 12'h5);
    multi = 1'b1;
    repeat (40) @(negedge clk_i);
    check("multi unsel", {10'h0, ofoe, ooe}, 12'h0);
    rsel_n = 1'b0;
    repeat (40) @(negedge clk_i);
    check("multi sel", {10'h0, ofoe, ooe}, 12'h2);
    $display("test phy role done");
    final_report();
  end
endmodule
`default_nettype wire
